// ==== src/can_ctl_pkg.sv ====
package can_ctl_pkg;
	// ==================================================================
	// register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ERRCNT = 8'h08;
	localparam logic [7:0] ADDR_ERRFLAG = 8'h0C;
	localparam logic [7:0] ADDR_STAMP = 8'h10;
	localparam logic [15:0] RD_NONE = 16'h0000;

	// ==================================================================
	// can_channel_control field positions
	localparam int MODE_LSB = 0;
	localparam int SLEEP_BIT = 2;
	localparam int POLICY_LSB = 3;
	localparam int FORCE_BIT = 5;
	localparam int TSRST_BIT = 6;
	localparam int TIMESTAMP_PRESCALE_LSB = 7;
	localparam int MBOX_BIT = 9;
	localparam int IDF_LSB = 10;
	localparam int LOST_BIT = 12;
	localparam int PRIO_BIT = 13;

	// channel_status field positions
	localparam int ST_MODE_LSB = 0;
	localparam int ST_SLEEP_BIT = 2;
	localparam int ST_BOFF_BIT = 3;
	localparam int ST_PASS_BIT = 4;
	localparam int ST_WARN_BIT = 5;

	// error counter register layout
	localparam int TEC_LSB = 0;
	localparam int REC_LSB = 8;

	// sticky error flags: six bus errors then four state events
	localparam int BUS_ERR_W = 6;
	localparam int ERRF_W = 10;

	// ==================================================================
	// encodings
	localparam logic [1:0] MODE_OPER = 2'h0;
	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam logic [1:0] MODE_HALT = 2'h2;
	localparam logic [1:0] POL_ISO = 2'h0;
	localparam logic [1:0] POL_HALT_ENTRY = 2'h1;
	localparam logic [1:0] POL_HALT_END = 2'h2;
	localparam logic [1:0] POL_HALT_SW = 2'h3;
	localparam logic [1:0] IDF_STD = 2'h0;
	localparam int STD_ID_W = 11;
	localparam int EXT_ID_W = 29;

	// mailboxes and acceptance masks
	localparam int NUM_MBOX = 32;
	localparam int NUM_MASKS = 8;
	localparam int MBOX_PER_MASK = 4;
	localparam int MBOX_W = 5;
	localparam int MASK_W = 3;
	localparam int GRP_SHIFT = 2;

	// bus-off recovery: 11-recessive-bit sequences needed
	localparam logic [7:0] RECOV_SEQ = 8'h80;
	localparam logic [7:0] SEQ_ZERO = 8'h00;

	// time stamp
	localparam int STAMP_W = 16;
	localparam logic [15:0] STAMP_ZERO = 16'h0000;
	localparam logic [15:0] STAMP_ONE = 16'h0001;
	localparam logic [2:0] PRE_ZERO = 3'h0;
	localparam logic [2:0] PRE_ONE = 3'h1;

	typedef enum logic [1:0] {
		BO_ACTIVE = 2'b01,
		BO_OFF = 2'b10
	} busoff_e;
endpackage

// ==== src/can_mode_and_busoff_control.sv ====
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - frames carry 11-bit standard or 29-bit extended identifiers.
// - 32 mailboxes; FIFO arrangement gives 24 normal, 4 transmit, 4 receive.
// - eight acceptance masks, each shared by four consecutive mailboxes.
// - 16-bit time stamp advances every 1, 2, 4 or 8 bit times in operation mode.
// - storing a message captures the current time stamp with it.
// - a message seen on the bus raises the wake-up request.
// - forced recovery and stamp reset self-clear and read as zero.
// - automatic halt entry sets mode select to 10b by hardware.
// - sleep request 1 stops the clock in reset or halt mode, 0 resumes.
// - policy 00b recovers after 128 sequences with recovery interrupt.
// - policy 01b halts at bus-off entry; recovery silent, counters cleared.
// - policy 10b marks halt at entry, halts after recovery, with interrupt.
// - policy 11b halts on software halt write; interrupt if recovered first.
// - software reset request beats coinciding automatic halt entry.
// - forced recovery clears counters and bus-off flag, no interrupt.
// - bus errors and error state transitions flagged; counters readable.
module can_mode_and_busoff_control
	import can_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [DATA_W-1:0] rdData,
	// protocol engine side
	input wire logic busIdle,
	input wire logic busOffEntry,
	input wire logic recessiveRun,
	input wire logic [BUS_ERR_W-1:0] busErr,
	input wire logic errWarning,
	input wire logic errPassive,
	input wire logic [7:0] txErrCnt,
	input wire logic [7:0] rxErrCnt,
	input wire logic msgDetect,
	input wire logic msgStored,
	input wire logic [MBOX_W-1:0] storeBox,
	input wire logic bitTick,
	// control toward the channel
	output logic [1:0] opMode,
	output logic clockStop,
	output logic busOffFlag,
	output logic errCountClear,
	output logic recoveryIrq,
	output logic wakeIrq,
	output logic [1:0] idFormat,
	output logic mailboxFifo,
	output logic lostOverrun,
	output logic txPrioBox,
	output logic [STAMP_W-1:0] stampValue,
	output logic stampWrite,
	output logic [MBOX_W-1:0] stampBox,
	output logic [MASK_W-1:0] maskGroup
);
	typedef struct packed {
		logic [1:0] modeSel;
		logic sleepReq;
		logic [1:0] policy;
		logic [1:0] tsPrescale;
		logic mbxFifo;
		logic [1:0] idFmt;
		logic lostOvr;
		logic prioBox;
		logic [1:0] effMode;
		logic sleepAct;
		busoff_e boState;
		logic [7:0] seqCnt;
		logic [ERRF_W-1:0] errFlags;
		logic warnPrev;
		logic passPrev;
		logic cntClear;
		logic recovIrq;
		logic wakeIrq;
		logic tsClear;
		logic [STAMP_W-1:0] stampVal;
		logic stampWr;
		logic [MBOX_W-1:0] stampBox;
		logic [MASK_W-1:0] maskGrp;
		logic [DATA_W-1:0] rdData;
	} ctl_s;

	ctl_s r_q;
	ctl_s r_d;
	logic [STAMP_W-1:0] tsCount;
	logic wrCtl;
	logic swReset;
	logic recoverEvt;
	logic holdMode;
	logic [1:0] wrMode;

	// ==================================================================
	// time stamp counter, only counting in operation mode
	timestamp_counter u_stamp (
		.clk(clk),
		.arst_n(arst_n),
		.run(r_q.effMode == MODE_OPER),
		.bitTick(bitTick),
		.prescale(r_q.tsPrescale),
		.clear(r_q.tsClear),
		.count(tsCount)
	);

	// ==================================================================
	// next-state logic
	always_comb begin
		r_d = r_q;
		r_d.cntClear = 1'b0;
		r_d.recovIrq = 1'b0;
		r_d.wakeIrq = 1'b0;
		r_d.stampWr = 1'b0;
		r_d.tsClear = 1'b0;
		r_d.rdData = RD_NONE;
		recoverEvt = 1'b0;
		wrCtl = wrEn && (addr == ADDR_CTRL);
		wrMode = wrData[MODE_LSB +: 2];
		swReset = wrCtl && (wrMode == MODE_RESET);

		// control register write; software keeps the mode-only guards
		if (wrCtl) begin
			r_d.modeSel = wrMode;
			r_d.sleepReq = wrData[SLEEP_BIT];
			r_d.policy = wrData[POLICY_LSB +: 2];
			r_d.tsPrescale = wrData[TIMESTAMP_PRESCALE_LSB +: 2];
			r_d.mbxFifo = wrData[MBOX_BIT];
			r_d.idFmt = wrData[IDF_LSB +: 2];
			r_d.lostOvr = wrData[LOST_BIT];
			r_d.prioBox = wrData[PRIO_BIT];
			r_d.tsClear = wrData[TSRST_BIT];
		end

		// bus-off recovery machine
		unique case (r_q.boState)
			BO_ACTIVE: begin
				if (busOffEntry) begin
					r_d.boState = BO_OFF;
					r_d.seqCnt = SEQ_ZERO;
					// halt marked at entry, unless reset was asked this cycle
					if ((r_q.policy == POL_HALT_ENTRY || r_q.policy == POL_HALT_END)
							&& !swReset) begin
						r_d.modeSel = MODE_HALT;
					end
				end
			end
			BO_OFF: begin
				if (wrCtl && wrData[FORCE_BIT]) begin
					// forced: no interrupt, no event flag
					r_d.boState = BO_ACTIVE;
					r_d.cntClear = 1'b1;
				end else if (r_q.policy == POL_HALT_SW && wrCtl
						&& wrMode == MODE_HALT) begin
					r_d.boState = BO_ACTIVE;
					r_d.cntClear = 1'b1;
				end else if (recessiveRun) begin
					if (r_q.seqCnt == RECOV_SEQ - 8'h01) begin
						r_d.boState = BO_ACTIVE;
						r_d.cntClear = 1'b1;
						recoverEvt = 1'b1;
						r_d.recovIrq = (r_q.policy != POL_HALT_ENTRY);
						if (r_q.policy == POL_HALT_END && !swReset) begin
							r_d.modeSel = MODE_HALT;
						end
					end else begin
						r_d.seqCnt = r_q.seqCnt + 8'h01;
					end
				end
			end
		endcase

		// mode takes effect: stopping waits for an idle bus
		holdMode = (r_d.boState == BO_OFF) && (r_q.policy == POL_HALT_END);
		if (!holdMode && r_d.modeSel != r_q.effMode
				&& (r_d.modeSel == MODE_OPER || busIdle)) begin
			r_d.effMode = r_d.modeSel;
		end

		// sleep only from reset or halt
		if (!r_q.sleepReq) begin
			r_d.sleepAct = 1'b0;
		end else if (r_q.effMode != MODE_OPER) begin
			r_d.sleepAct = 1'b1;
		end

		r_d.wakeIrq = msgDetect;

		// sticky error flags: clear by writing one, a new event wins
		if (wrEn && addr == ADDR_ERRFLAG) begin
			r_d.errFlags = r_q.errFlags & ~wrData[ERRF_W-1:0];
		end
		r_d.errFlags = r_d.errFlags | {recoverEvt,
			(r_q.boState == BO_ACTIVE) && busOffEntry,
			errPassive && !r_q.passPrev,
			errWarning && !r_q.warnPrev,
			busErr};
		r_d.warnPrev = errWarning;
		r_d.passPrev = errPassive;

		// capture stamp and mask group with each stored message
		if (msgStored) begin
			r_d.stampVal = tsCount;
			r_d.stampWr = 1'b1;
			r_d.stampBox = storeBox;
			r_d.maskGrp = MASK_W'(storeBox >> GRP_SHIFT);
		end

		// reads answer one cycle later; unmapped reads give zero
		if (rdEn) begin
			unique case (addr)
				ADDR_CTRL: begin
					// self-clearing bits read back as zero
					r_d.rdData[MODE_LSB +: 2] = r_q.modeSel;
					r_d.rdData[SLEEP_BIT] = r_q.sleepReq;
					r_d.rdData[POLICY_LSB +: 2] = r_q.policy;
					r_d.rdData[TIMESTAMP_PRESCALE_LSB +: 2] = r_q.tsPrescale;
					r_d.rdData[MBOX_BIT] = r_q.mbxFifo;
					r_d.rdData[IDF_LSB +: 2] = r_q.idFmt;
					r_d.rdData[LOST_BIT] = r_q.lostOvr;
					r_d.rdData[PRIO_BIT] = r_q.prioBox;
				end
				ADDR_STATUS: begin
					r_d.rdData[ST_MODE_LSB +: 2] = r_q.effMode;
					r_d.rdData[ST_SLEEP_BIT] = r_q.sleepAct;
					r_d.rdData[ST_BOFF_BIT] = (r_q.boState == BO_OFF);
					r_d.rdData[ST_PASS_BIT] = errPassive;
					r_d.rdData[ST_WARN_BIT] = errWarning;
				end
				ADDR_ERRCNT: begin
					r_d.rdData[TEC_LSB +: 8] = txErrCnt;
					r_d.rdData[REC_LSB +: 8] = rxErrCnt;
				end
				ADDR_ERRFLAG: r_d.rdData[ERRF_W-1:0] = r_q.errFlags;
				ADDR_STAMP: r_d.rdData = tsCount;
				default: r_d.rdData = RD_NONE;
			endcase
		end
	end

	// ==================================================================
	// state register; leaves reset in reset mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= '0;
			r_q.modeSel <= MODE_RESET;
			r_q.effMode <= MODE_RESET;
			r_q.boState <= BO_ACTIVE;
		end else begin
			r_q <= r_d;
		end
	end

	// ==================================================================
	// outputs, all straight from the state register
	assign rdData = r_q.rdData;
	assign opMode = r_q.effMode;
	assign clockStop = r_q.sleepAct;
	assign busOffFlag = (r_q.boState == BO_OFF);
	assign errCountClear = r_q.cntClear;
	assign recoveryIrq = r_q.recovIrq;
	assign wakeIrq = r_q.wakeIrq;
	assign idFormat = r_q.idFmt;
	assign mailboxFifo = r_q.mbxFifo;
	assign lostOverrun = r_q.lostOvr;
	assign txPrioBox = r_q.prioBox;
	assign stampValue = r_q.stampVal;
	assign stampWrite = r_q.stampWr;
	assign stampBox = r_q.stampBox;
	assign maskGroup = r_q.maskGrp;
endmodule

// ==== src/timestamp_counter.sv ====
`timescale 1ns/1ps
module timestamp_counter
	import can_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic bitTick,
	input wire logic [1:0] prescale,
	input wire logic clear,
	output logic [STAMP_W-1:0] count
);
	typedef struct packed {
		logic [2:0] div;
		logic [STAMP_W-1:0] cnt;
	} ts_s;

	ts_s r_q;
	ts_s r_d;
	logic [2:0] divLast;

	// ==================================================================
	// prescaled 16-bit counter
	// divide by 1, 2, 4 or 8 bit times
	always_comb begin
		r_d = r_q;
		divLast = 3'((4'h1 << prescale) - 4'h1);
		if (clear) begin
			r_d.div = PRE_ZERO;
			r_d.cnt = STAMP_ZERO;
		end else if (run && bitTick) begin
			if (r_q.div >= divLast) begin
				r_d.div = PRE_ZERO;
				r_d.cnt = r_q.cnt + STAMP_ONE; // wraps at 16 bits
			end else begin
				r_d.div = r_q.div + PRE_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign count = r_q.cnt;
endmodule

// ==== tb/engine_model.sv ====
`timescale 1ns/1ps
// ======
// protocol engine stand-in: bus-off, recessive runs, counters, bit ticks
module engine_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic kick,
	input wire logic tickEn,
	input wire logic errCountClear,
	output logic busOffEntry,
	output logic recessiveRun,
	output logic bitTick,
	output logic [15:0] errCnt
);
	int runs;
	int ph;
	// runs spaced three cycles; a counter clear ends them, as a real engine would
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{busOffEntry, recessiveRun, bitTick} <= 3'h0;
			errCnt <= 16'h0000;
			runs <= 0;
			ph <= 0;
		end else begin
			ph <= ph + 1;
			busOffEntry <= kick;
			bitTick <= tickEn && ph % 4 == 0;
			recessiveRun <= runs > 0 && ph % 3 == 0;
			if (runs > 0 && ph % 3 == 0) runs <= runs - 1;
			if (kick) begin
				runs <= 128;
				errCnt <= 16'h9cff;
			end
			if (errCountClear) begin
				runs <= 0;
				errCnt <= 16'h0000;
			end
		end
	end
endmodule

// ==== tb/mode_chk.sv ====
`timescale 1ns/1ps
// ======
// port checker for the mode and bus-off block
module mode_chk
	import can_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic busOffEntry,
	input wire logic msgDetect,
	input wire logic msgStored,
	input wire logic [MBOX_W-1:0] storeBox,
	input wire logic [1:0] opMode,
	input wire logic clockStop,
	input wire logic busOffFlag,
	input wire logic errCountClear,
	input wire logic recoveryIrq,
	input wire logic wakeIrq,
	input wire logic stampWrite,
	input wire logic [MBOX_W-1:0] stampBox,
	input wire logic [MASK_W-1:0] maskGroup
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// control write in this cycle
	wire ctlWr = wrEn && addr == ADDR_CTRL;
	chk_wake_pulse: assert property (msgDetect |=> wakeIrq)
		else $error("no wake request");
	chk_stamp_box: assert property (msgStored |=> stampWrite && stampBox == $past(storeBox))
		else $error("stamp box wrong");
	chk_mask_group: assert property (msgStored |=> maskGroup == $past(storeBox[4:2]))
		else $error("mask group wrong");
	chk_selfclr_zero: assert property (rdEn && addr == ADDR_CTRL |=> !rdData[6] && !rdData[5])
		else $error("self-clearing bit read as one");
	chk_boff_flag: assert property (busOffEntry |=> busOffFlag)
		else $error("bus-off flag missing");
	chk_forced_exit: assert property (ctlWr && wrData[5] && busOffFlag |=>
		!busOffFlag && errCountClear && !recoveryIrq) else $error("forced recovery wrong");
	chk_irq_clears: assert property (recoveryIrq |-> errCountClear)
		else $error("recovery without counter clear");
	chk_sleep_halt: assert property (clockStop |-> opMode != MODE_OPER)
		else $error("sleep while operating");
endmodule
bind can_mode_and_busoff_control mode_chk chk_u (.clk, .arst_n, .addr, .wrData, .wrEn, .rdEn,
	.rdData, .busOffEntry, .msgDetect, .msgStored, .storeBox, .opMode, .clockStop, .busOffFlag,
	.errCountClear, .recoveryIrq, .wakeIrq, .stampWrite, .stampBox, .maskGroup);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// ======
// bench: bus tasks, reference values, bus-off sweep
module tb;
	import can_ctl_pkg::*;
	logic clk = 0, arst_n = 0, wrEn = 0, rdEn = 0, msgStored = 0, msgDetect = 0;
	logic kick = 0, tickEn = 0, busIdle = 1, errWarning = 0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wrData = 16'h0000, rdData, errCnt, stampValue, ctl, e;
	logic [5:0] busErr = 6'h00;
	logic [4:0] storeBox = 5'h00, stampBox;
	logic [2:0] maskGroup;
	logic [1:0] opMode, idFormat, p;
	logic busOffEntry, recessiveRun, bitTick, clockStop, busOffFlag, errCountClear;
	logic recoveryIrq, wakeIrq, mailboxFifo, lostOverrun, txPrioBox, stampWrite;
	int num_errors = 0, total_checks = 0, seed = 32'h8f18, irqs = 0, clrs = 0, ticks = 0;
	always #25 clk = ~clk;
	// pulse tallies; an unknown zeroes the whole tally and so shows up as misses
	always @(posedge clk) begin
		irqs += recoveryIrq;
		clrs += errCountClear;
		ticks += bitTick;
	end
	engine_model eng_u (.clk, .arst_n, .kick, .tickEn, .errCountClear, .busOffEntry,
		.recessiveRun, .bitTick, .errCnt);
	can_mode_and_busoff_control dut_u (.clk, .arst_n, .addr, .wrData, .wrEn, .rdEn, .rdData,
		.busIdle, .busOffEntry, .recessiveRun, .busErr, .errWarning, .errPassive(1'b0),
		.txErrCnt(errCnt[7:0]), .rxErrCnt(errCnt[15:8]), .msgDetect, .msgStored, .storeBox,
		.bitTick, .opMode, .clockStop, .busOffFlag, .errCountClear, .recoveryIrq, .wakeIrq,
		.idFormat, .mailboxFifo, .lostOverrun, .txPrioBox, .stampValue, .stampWrite,
		.stampBox, .maskGroup);
	// ======
	// compare and bus tasks
	task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1;
		@(posedge clk);
		wrEn <= 0;
	endtask
	// control write; the model keeps it minus the self-clearing bits
	task automatic setc(input logic [15:0] d);
		wr(ADDR_CTRL, d);
		ctl = d & 16'h3f9f;
	endtask
	task automatic cmp_rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rdEn <= 1;
		@(posedge clk);
		rdEn <= 0;
		#1 cmp_pin(rdData, exp);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ======
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1;
		cmp_rd(ADDR_CTRL, 16'h0001);
		cmp_rd(ADDR_STATUS, 16'h0001);
		// random config in reset mode; prescale kept 0 so stamp counts every tick
		// no forced recovery or stamp reset here: neither is allowed in reset mode
		setc(($random(seed) & 16'h3618) | 16'h0001);
		cmp_rd(ADDR_CTRL, ctl);
		cmp_pin({2'h0, txPrioBox, lostOverrun, idFormat, mailboxFifo, 9'h000}, ctl & 16'h3e00);
		setc(ctl | 16'h0004);
		@(posedge clk);
		#1 cmp_pin({15'h0000, clockStop}, 16'h0001);
		setc(ctl & 16'hfffb);
		@(posedge clk);
		#1 cmp_pin({15'h0000, clockStop}, 16'h0000);
		// sticky error and warning flags, then write-one clear
		e = ($random(seed) & 16'h003f) | 16'h0040;
		busErr <= e[5:0];
		errWarning <= 1;
		@(posedge clk);
		busErr <= 6'h00;
		cmp_rd(ADDR_ERRFLAG, e);
		wr(ADDR_ERRFLAG, e);
		cmp_rd(ADDR_ERRFLAG, 16'h0000);
		setc(ctl & 16'hfffc);
		tickEn <= 1;
		@(posedge clk);
		#1 cmp_pin({14'h0000, opMode}, 16'h0000);
		// software polls status before touching mode again; warning level still high
		cmp_rd(ADDR_STATUS, 16'h0020);
		// stored messages echo box, group and a wake request
		repeat (8) begin
			@(posedge clk);
			storeBox <= $random(seed);
			msgStored <= 1;
			msgDetect <= 1;
			@(posedge clk);
			msgStored <= 0;
			msgDetect <= 0;
			#1 cmp_pin({stampBox, maskGroup, 7'h00, wakeIrq}, {storeBox, storeBox[4:2], 8'h01});
		end
		// stamp reset with ticks held off, then a counted run of ticks
		tickEn <= 0;
		repeat (3) @(posedge clk);
		wr(ADDR_CTRL, ctl | 16'h0040);
		repeat (2) @(posedge clk);
		cmp_rd(ADDR_STAMP, 16'h0000);
		ticks = 0;
		tickEn <= 1;
		repeat (90) @(posedge clk);
		tickEn <= 0;
		repeat (4) @(posedge clk);
		cmp_rd(ADDR_STAMP, 16'(ticks));
		// a stored message captures the stamp value now standing
		@(posedge clk);
		msgStored <= 1;
		@(posedge clk);
		msgStored <= 0;
		#1 cmp_pin(stampValue, 16'(ticks));
		// bus-off under each policy; the fifth pass is forced recovery under 00b
		for (int i = 0; i < 5; i++) begin
			p = 2'(i % 4);
			setc((ctl & 16'hfffc) | 16'h0001);
			setc((ctl & 16'hffe7) | {11'h000, p, 3'h0});
			setc(ctl & 16'hfffc);
			irqs = 0;
			clrs = 0;
			kick <= 1;
			@(posedge clk);
			kick <= 0;
			repeat (2) @(posedge clk);
			if (p == POL_HALT_ENTRY || p == POL_HALT_END) ctl[1:0] = MODE_HALT;
			#1 cmp_pin({15'h0000, busOffFlag}, 16'h0001);
			cmp_rd(ADDR_CTRL, ctl);
			cmp_rd(ADDR_ERRCNT, 16'h9cff);
			if (i == 4) setc(ctl | 16'h0020);
			if (p == POL_HALT_SW) setc(ctl | 16'h0002);
			for (int n = 0; busOffFlag !== 1'b0; n++) begin
				if (n == 1000) begin
					num_errors++;
					stop_test();
				end
				@(posedge clk);
			end
			repeat (3) @(posedge clk);
			#1 cmp_pin(16'(irqs), 16'(i == 0 || i == 2));
			cmp_pin(16'(clrs), 16'h0001);
			cmp_pin({14'h0000, opMode}, p == POL_ISO ? 16'h0000 : 16'h0002);
		end
		stop_test();
	end
endmodule
